// ===== rtl/pcr_consts.svh
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// Register byte addresses
`define PCR_ADDR_DAC4 16'h8437
`define PCR_ADDR_CFG 16'h8438
`define PCR_ADDR_GLOB 16'h8439
`define PCR_ADDR_PLL 16'h843E
`define PCR_ADDR_SRT 16'h843F

// Field positions
`define PCR_CFG_OFF_LSB 0
`define PCR_CFG_OFF_MSB 2
`define PCR_CFG_CON_LSB 3
`define PCR_CFG_CON_MSB 4
`define PCR_CFG_FS 5
`define PCR_CFG_MIX 6
`define PCR_GLOB_BLANK 0
`define PCR_GLOB_PD 1
`define PCR_PLL_RNG_LSB 0
`define PCR_PLL_RNG_MSB 1
`define PCR_PLL_VBLANK 2
`define PCR_PLL_OVR 3
`define PCR_PLL_CLAMP 5
`define PCR_SRT_RESET 0
`define PCR_SRT_AID 6

// Writable bit masks; reserved bits store nothing and read zero
`define PCR_MASK_CFG 8'h7F
`define PCR_MASK_GLOB 8'h03
`define PCR_MASK_PLL 8'h2F

// Default values
`define PCR_DEF_DAC4 8'h00
`define PCR_DEF_CFG 8'h00
`define PCR_DEF_GLOB 8'h00
`define PCR_DEF_PLL 8'h00
`define PCR_DEF_AID 1'h0

// Serial bus slave address, value arbitrary
`define PCR_DEF_DEV_ADDR 7'h2E

`endif

// ===== rtl/pcr_pkg.sv
package pcr_pkg;
  typedef logic [7:0] pcr_byte_t;
  typedef logic [15:0] pcr_addr_t;
  typedef enum {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_RACK} pcr_state_t;
  typedef enum {PH_DEV, PH_AHI, PH_ALO, PH_DATA} pcr_phase_t;
endpackage

// ===== rtl/pcr_reg_if.sv
`timescale 1ns/1ps
interface pcr_reg_if;
  logic wr;
  pcr_pkg::pcr_addr_t addr;
  pcr_pkg::pcr_byte_t wdata;
  pcr_pkg::pcr_byte_t rdata;
  logic auto_increment_disable;
  modport bank (input wr, input addr, input wdata, output rdata, output auto_increment_disable);
  modport master (output wr, output addr, output wdata, input rdata, input auto_increment_disable);
endinterface

// ===== rtl/pcr_reg_bank.sv
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_reg_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access
  pcr_reg_if.bank rif,
  // Clamp pulse in and normalised out
  input wire logic clamp_in,
  output logic clamp_active,
  // Control fields
  output pcr_pkg::pcr_byte_t dac_four_code,
  output pcr_pkg::pcr_byte_t dac_four_half_add,
  output logic dac_four_mix_enable,
  output logic dac_fullscale_select,
  output logic [2:0] video_offset,
  output logic [1:0] overlay_contrast,
  output logic video_blank_force,
  output logic analog_power_down,
  output logic [1:0] pll_range,
  output logic vertical_blank_gate,
  output logic overlay_only_override,
  output logic soft_reset_busy
);
  import pcr_pkg::*;

  pcr_byte_t reg_dac4, reg_cfg, reg_glob, reg_pll, rdata, mix_half;
  pcr_byte_t next_dac4, next_cfg, next_glob, next_pll, next_rdata, next_mix_half;
  logic soft_rst, auto_increment_disable, clamp_q;
  logic next_soft_rst, next_aid, next_clamp_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_dac4 = reg_dac4;
    next_cfg = reg_cfg;
    next_glob = reg_glob;
    next_pll = reg_pll;
    next_aid = auto_increment_disable;
    next_soft_rst = 1'b0;
    if (soft_rst) begin
      // Only registers; the bus slave keeps its transfer
      next_dac4 = `PCR_DEF_DAC4;
      next_cfg = `PCR_DEF_CFG;
      next_glob = `PCR_DEF_GLOB;
      next_pll = `PCR_DEF_PLL;
    end else if (rif.wr) begin
      case (rif.addr)
        `PCR_ADDR_DAC4: next_dac4 = rif.wdata;
        `PCR_ADDR_CFG: next_cfg = rif.wdata & `PCR_MASK_CFG;
        `PCR_ADDR_GLOB: next_glob = rif.wdata & `PCR_MASK_GLOB;
        `PCR_ADDR_PLL: next_pll = rif.wdata & `PCR_MASK_PLL;
        `PCR_ADDR_SRT: begin
          next_aid = rif.wdata[`PCR_SRT_AID];
          next_soft_rst = rif.wdata[`PCR_SRT_RESET];
        end
        default: ;
      endcase
    end
    case (rif.addr)
      `PCR_ADDR_DAC4: next_rdata = reg_dac4;
      `PCR_ADDR_CFG: next_rdata = reg_cfg;
      `PCR_ADDR_GLOB: next_rdata = reg_glob;
      `PCR_ADDR_PLL: next_rdata = reg_pll;
      `PCR_ADDR_SRT: next_rdata = {1'b0, auto_increment_disable, 5'h00, soft_rst};
      default: next_rdata = 8'h00;
    endcase
    next_mix_half = reg_cfg[`PCR_CFG_MIX] ? {1'b0, reg_dac4[7:1]} : 8'h00;
    next_clamp_q = clamp_in ^ reg_pll[`PCR_PLL_CLAMP];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_dac4 <= `PCR_DEF_DAC4;
      reg_cfg <= `PCR_DEF_CFG;
      reg_glob <= `PCR_DEF_GLOB;
      reg_pll <= `PCR_DEF_PLL;
      auto_increment_disable <= `PCR_DEF_AID;
      soft_rst <= 1'b0;
      rdata <= 8'h00;
      mix_half <= 8'h00;
      clamp_q <= 1'b0;
    end else begin
      reg_dac4 <= next_dac4;
      reg_cfg <= next_cfg;
      reg_glob <= next_glob;
      reg_pll <= next_pll;
      auto_increment_disable <= next_aid;
      soft_rst <= next_soft_rst;
      rdata <= next_rdata;
      mix_half <= next_mix_half;
      clamp_q <= next_clamp_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rif.rdata = rdata;
  assign rif.auto_increment_disable = auto_increment_disable;
  assign clamp_active = clamp_q;
  assign dac_four_code = reg_dac4;
  assign dac_four_half_add = mix_half;
  assign dac_four_mix_enable = reg_cfg[`PCR_CFG_MIX];
  assign dac_fullscale_select = reg_cfg[`PCR_CFG_FS];
  assign video_offset = reg_cfg[`PCR_CFG_OFF_MSB:`PCR_CFG_OFF_LSB];
  assign overlay_contrast = reg_cfg[`PCR_CFG_CON_MSB:`PCR_CFG_CON_LSB];
  assign video_blank_force = reg_glob[`PCR_GLOB_BLANK];
  assign analog_power_down = reg_glob[`PCR_GLOB_PD];
  assign pll_range = reg_pll[`PCR_PLL_RNG_MSB:`PCR_PLL_RNG_LSB];
  assign vertical_blank_gate = reg_pll[`PCR_PLL_VBLANK];
  assign overlay_only_override = reg_pll[`PCR_PLL_OVR];
  assign soft_reset_busy = soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rst_req;
    rif.wr && rif.addr == `PCR_ADDR_SRT && rif.wdata[`PCR_SRT_RESET];
  endsequence
  sequence s_rst_done;
    soft_rst ##1 (!soft_rst && reg_dac4 == `PCR_DEF_DAC4 && reg_cfg == `PCR_DEF_CFG
      && reg_glob == `PCR_DEF_GLOB && reg_pll == `PCR_DEF_PLL);
  endsequence

  chk_dac4_write: assert property (rif.wr && !soft_rst && rif.addr == `PCR_ADDR_DAC4
    |=> dac_four_code == $past(rif.wdata)) else $error("dac four code not stored");
  chk_offset_contrast: assert property (rif.wr && !soft_rst && rif.addr == `PCR_ADDR_CFG
    |=> video_offset == $past(rif.wdata[2:0]) && overlay_contrast == $past(rif.wdata[4:3])
    && dac_fullscale_select == $past(rif.wdata[5])) else $error("config fields wrong");
  chk_mix_half: assert property (##1 dac_four_half_add ==
    ($past(dac_four_mix_enable) ? {1'b0, $past(dac_four_code[7:1])} : 8'h00))
    else $error("dac four mix term wrong");
  chk_blank_power: assert property (rif.wr && !soft_rst && rif.addr == `PCR_ADDR_GLOB
    |=> video_blank_force == $past(rif.wdata[0]) && analog_power_down == $past(rif.wdata[1]))
    else $error("global control fields wrong");
  chk_pll_options: assert property (rif.wr && !soft_rst && rif.addr == `PCR_ADDR_PLL
    |=> vertical_blank_gate == $past(rif.wdata[2]) && overlay_only_override == $past(rif.wdata[3]))
    else $error("pll option fields wrong");
  chk_clamp_pol: assert property (##1 clamp_active ==
    ($past(clamp_in) ^ $past(reg_pll[`PCR_PLL_CLAMP]))) else $error("clamp polarity wrong");
  chk_rst_defaults: assert property (s_rst_req |=> s_rst_done)
    else $error("soft reset did not load defaults and clear");
  chk_rst_keeps_aid: assert property (s_rst_req |=> ##1 auto_increment_disable == $past(rif.wdata[6], 2))
    else $error("soft reset disturbed auto increment bit");
endmodule // pcr_reg_bank

// ===== rtl/pcr_top.sv
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_top #(
  parameter logic [6:0] DEV_ADDR = `PCR_DEF_DEV_ADDR,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial bus, open drain data
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Clamp pulse
  input wire logic clamp_in,
  output logic clamp_active,
  // Controlled functions
  output pcr_pkg::pcr_byte_t dac_four_code,
  output pcr_pkg::pcr_byte_t dac_four_half_add,
  output logic dac_four_mix_enable,
  output logic dac_fullscale_select,
  output logic [2:0] video_offset,
  output logic [1:0] overlay_contrast,
  output logic video_blank_force,
  output logic analog_power_down,
  output logic [1:0] pll_range,
  output logic vertical_blank_gate,
  output logic overlay_only_override,
  output logic soft_reset_busy
);
  import pcr_pkg::*;

  if (ADDR_W != 16) begin : g_chk
    $error("pcr_top serves only 16-bit register addresses");
  end

  pcr_reg_if rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus line edges
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_i;
  assign bus_stop = scl & scl_q & ~sda_q & sda_i;

  ////////////////////////////////////////////////////////////////////////////
  // Slave state
  pcr_state_t state, next_state;
  pcr_phase_t phase, next_phase;
  logic [3:0] cnt, next_cnt;
  pcr_byte_t shreg, next_shreg;
  pcr_addr_t reg_addr, next_reg_addr;
  logic is_read, next_is_read;
  logic oe, next_oe;
  logic wr;

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt = cnt;
    next_shreg = shreg;
    next_reg_addr = reg_addr;
    next_is_read = is_read;
    next_oe = oe;
    wr = 1'b0;
    if (bus_start) begin
      next_state = ST_RECV;
      next_phase = PH_DEV;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (bus_stop) begin
      next_state = ST_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        ST_IDLE: ;
        ST_RECV: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_i};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_state = ST_ACK;
            next_oe = 1'b1;
            case (phase)
              PH_DEV: begin
                next_is_read = shreg[0];
                if (shreg[7:1] != DEV_ADDR) begin
                  next_state = ST_IDLE;
                  next_oe = 1'b0;
                end
              end
              PH_AHI: next_reg_addr[15:8] = shreg;
              PH_ALO: next_reg_addr[7:0] = shreg;
              PH_DATA: wr = 1'b1;
              default: ;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = ST_RECV;
            case (phase)
              PH_DEV: begin
                if (is_read) begin
                  next_state = ST_SEND;
                  next_shreg = rif.rdata;
                  next_oe = ~rif.rdata[7];
                end else begin
                  next_phase = PH_AHI;
                end
              end
              PH_AHI: next_phase = PH_ALO;
              PH_ALO: next_phase = PH_DATA;
              PH_DATA: begin
                if (!rif.auto_increment_disable) begin
                  next_reg_addr = reg_addr + 16'h0001;
                end
              end
              default: ;
            endcase
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (cnt == 4'h7) begin
              next_state = ST_RACK;
              next_oe = 1'b0;
              next_cnt = 4'h0;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_i) begin
              next_state = ST_IDLE;
            end else if (!rif.auto_increment_disable) begin
              next_reg_addr = reg_addr + 16'h0001;
            end
          end else if (scl_fall) begin
            next_state = ST_SEND;
            next_shreg = rif.rdata;
            next_oe = ~rif.rdata[7];
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Soft reset never reaches this process, so a transfer finishes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= ST_IDLE;
      phase <= PH_DEV;
      cnt <= 4'h0;
      shreg <= 8'h00;
      reg_addr <= 16'h0000;
      is_read <= 1'b0;
      oe <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_i;
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      shreg <= next_shreg;
      reg_addr <= next_reg_addr;
      is_read <= next_is_read;
      oe <= next_oe;
    end
  end

  assign rif.wr = wr;
  assign rif.addr = reg_addr;
  assign rif.wdata = shreg;
  assign sda_o = 1'b0;
  assign sda_oe = oe;

  ////////////////////////////////////////////////////////////////////////////
  pcr_reg_bank u_bank (
    .clk(clk),
    .rstn(rstn),
    .rif(rif.bank),
    .clamp_in(clamp_in),
    .clamp_active(clamp_active),
    .dac_four_code(dac_four_code),
    .dac_four_half_add(dac_four_half_add),
    .dac_four_mix_enable(dac_four_mix_enable),
    .dac_fullscale_select(dac_fullscale_select),
    .video_offset(video_offset),
    .overlay_contrast(overlay_contrast),
    .video_blank_force(video_blank_force),
    .analog_power_down(analog_power_down),
    .pll_range(pll_range),
    .vertical_blank_gate(vertical_blank_gate),
    .overlay_only_override(overlay_only_override),
    .soft_reset_busy(soft_reset_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_write_on_byte: assert property (wr |-> state == ST_RECV && phase == PH_DATA
    && cnt == 4'h8 ##1 state == ST_ACK && sda_oe) else $error("write not at byte end");
  chk_addr_step: assert property (state == ST_ACK && phase == PH_DATA && scl_fall
    && !bus_start && !bus_stop && !rif.auto_increment_disable |=> reg_addr == $past(reg_addr) + 16'h0001)
    else $error("auto increment missing");
  chk_addr_hold: assert property (state == ST_ACK && phase == PH_DATA && scl_fall
    && !bus_start && !bus_stop && rif.auto_increment_disable |=> reg_addr == $past(reg_addr))
    else $error("address moved with increment disabled");
  chk_rst_bus_kept: assert property (soft_reset_busy && !bus_start && !bus_stop
    && !scl_rise && !scl_fall |=> state == $past(state) && reg_addr == $past(reg_addr))
    else $error("soft reset disturbed bus transfer");
  chk_power_field: assert property (wr && !soft_reset_busy && reg_addr == `PCR_ADDR_GLOB
    |=> analog_power_down == $past(shreg[1])) else $error("power down not applied");
  chk_override_field: assert property (wr && !soft_reset_busy && reg_addr == `PCR_ADDR_PLL
    |=> overlay_only_override == $past(shreg[3])) else $error("override not applied");
endmodule // pcr_top

// ===== bench/pcr_host_model.sv
`timescale 1ns/1ps
module pcr_host_model #(
  parameter int P = 5
) (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda_line,
  // Driven serial lines, high means released
  output logic scl,
  output logic sda_h
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic hp;
    repeat (P) @(negedge clk);
  endtask
  // Also serves as repeated start
  task automatic start;
    sda_h = 1'b1; hp();
    scl = 1'b1; hp();
    sda_h = 1'b0; hp();
    scl = 1'b0; hp();
  endtask
  task automatic stop;
    sda_h = 1'b0; hp();
    scl = 1'b1; hp();
    sda_h = 1'b1; hp();
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_h = b; hp();
    scl = 1'b1; hp();
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(nack, s);
  endtask
endmodule // pcr_host_model

// ===== bench/pcr_top_tb_top.sv
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_top_tb_top;
  import pcr_pkg::*;
  localparam logic [6:0] DEV = `PCR_DEF_DEV_ADDR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clamp_in = 1'b0;
  logic scl, sda_h, sda_o, sda_oe, clamp_active;
  logic mix, fs, blank, pd, vgate, ovr, busy;
  logic [2:0] off;
  logic [1:0] con, rng;
  pcr_byte_t code, half, d;
  int err_count = 0;
  int n_tests = 0;
  int nack_cnt = 0;
  int busy_cnt = 0;
  logic a;
  wire sda_line = sda_h & (sda_oe ? sda_o : 1'b1);
  wire [7:0] cfg = {1'b0, mix, fs, con, off};
  wire [7:0] glob = {6'h00, pd, blank};
  wire [7:0] pll = {4'h0, ovr, vgate, rng};

  always #2.5 clk = ~clk;
  always @(posedge clk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

  pcr_host_model u_pcr_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_h(sda_h));
  pcr_top u_pcr_top (
    .clk(clk), .rstn(rstn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .clamp_in(clamp_in), .clamp_active(clamp_active), .dac_four_code(code),
    .dac_four_half_add(half), .dac_four_mix_enable(mix), .dac_fullscale_select(fs),
    .video_offset(off), .overlay_contrast(con), .video_blank_force(blank),
    .analog_power_down(pd), .pll_range(rng), .vertical_blank_gate(vgate),
    .overlay_only_override(ovr), .soft_reset_busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic results;
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] b);
    logic k;
    u_pcr_host_model.wbyte(b, k);
    if (k !== 1'b1) nack_cnt++;
  endtask
  task automatic wr_open(input logic [15:0] ad);
    u_pcr_host_model.start();
    wb({DEV, 1'b0});
    wb(ad[15:8]);
    wb(ad[7:0]);
  endtask
  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    wr_open(ad);
    wb(v);
    u_pcr_host_model.stop();
  endtask
  task automatic rd(input logic [15:0] ad, output logic [7:0] v);
    wr_open(ad);
    u_pcr_host_model.start();
    wb({DEV, 1'b1});
    u_pcr_host_model.rbyte(1'b1, v);
    u_pcr_host_model.stop();
  endtask
  task automatic clamp_chk(input logic lvl, input logic [7:0] exp);
    clamp_in = lvl;
    repeat (3) @(negedge clk);
    check({7'h00, clamp_active}, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #150us;
    err_count++;
    results();
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    rd(`PCR_ADDR_CFG, d);
    check(d, 8'h00);
    wr(`PCR_ADDR_DAC4, 8'hA5);
    check(code, 8'hA5);
    wr(`PCR_ADDR_CFG, 8'h5D);
    check(cfg, 8'h5D);
    check(half, 8'h52);
    wr(`PCR_ADDR_CFG, 8'h2A);
    check(cfg, 8'h2A);
    check(half, 8'h00);
    wr(`PCR_ADDR_CFG, 8'h7F);
    rd(`PCR_ADDR_CFG, d);
    check(d, 8'h7F);
    wr(`PCR_ADDR_GLOB, 8'h01);
    check(glob, 8'h01);
    wr(`PCR_ADDR_GLOB, 8'h02);
    check(glob, 8'h02);
    wr(`PCR_ADDR_PLL, 8'h2B);
    check(pll, 8'h0B);
    clamp_chk(1'b1, 8'h00);
    clamp_chk(1'b0, 8'h01);
    wr(`PCR_ADDR_PLL, 8'h06);
    check(pll, 8'h06);
    clamp_chk(1'b1, 8'h01);
    rd(`PCR_ADDR_PLL, d);
    check(d, 8'h06);
    wr_open(`PCR_ADDR_DAC4);
    wb(8'h11);
    wb(8'h22);
    u_pcr_host_model.stop();
    check(code, 8'h11);
    check(cfg, 8'h22);
    wr_open(`PCR_ADDR_DAC4);
    u_pcr_host_model.start();
    wb({DEV, 1'b1});
    u_pcr_host_model.rbyte(1'b0, d);
    check(d, 8'h11);
    u_pcr_host_model.rbyte(1'b1, d);
    check(d, 8'h22);
    u_pcr_host_model.stop();
    wr(`PCR_ADDR_SRT, 8'h40);
    wr_open(`PCR_ADDR_DAC4);
    wb(8'h33);
    wb(8'h44);
    u_pcr_host_model.stop();
    check(code, 8'h44);
    check(cfg, 8'h22);
    busy_cnt = 0;
    wr(`PCR_ADDR_SRT, 8'h41);
    check(busy_cnt[7:0], 8'h01);
    check(code | cfg | glob | pll, 8'h00);
    rd(`PCR_ADDR_SRT, d);
    check(d, 8'h40);
    check(nack_cnt[7:0], 8'h00);
    rd(16'h8440, d);
    check(d, 8'h00);
    u_pcr_host_model.start();
    u_pcr_host_model.wbyte({DEV ^ 7'h01, 1'b0}, a);
    u_pcr_host_model.stop();
    check({7'h00, a}, 8'h00);
    results();
  end
endmodule // pcr_top_tb_top
